// *** lsdc_driver.sv ***
`timescale 1ns/1ps
`default_nettype none

module lsdc_driver
  import lsdc_pkg::*;
(
  input wire logic ref_clk_in, // system clock, 100 MHz
  input wire logic reset_in, // async reset, active high
  input wire lsdc_pkg::lsdc_wb_req_t wb_req_in, // wishbone request
  output lsdc_pkg::lsdc_wb_rsp_t wb_rsp_out, // wishbone answer
  input wire logic sleep_in, // processor in sleep mode
  input wire logic tmr_tick_in, // secondary timer osc event
  input wire logic lfo_tick_in, // low-frequency osc event
  input wire logic [28:0] gpio_dat_in, // general I/O output data
  input wire logic [28:0] gpio_oe_in, // general I/O output enable
  output logic [3:0] com_out, // active common, one-hot
  output logic phase_out, // drive phase of the waveform
  output logic bias_half_out, // half bias selected
  output logic [28:0] pad_dat_out, // pad data
  output logic [28:0] pad_oe_out, // pad output enable
  output logic irq_out // level interrupt
);

  typedef struct packed {
    logic on;
    logic slp;
    logic wfail_flag;
    logic [1:0] src;
    logic [1:0] mux;
    logic wtype;
    logic bias;
    logic [3:0] pre;
    logic [1:0] istat;
    logic [1:0] imask;
    logic [3:0][7:0] segen;
    logic [23:0][7:0] pix;
    logic active;
    logic [1:0] com_idx;
    logic half;
    logic phase;
    logic ack;
    logic [31:0] rdat;
    logic [3:0] com;
    logic [28:0] pdat;
    logic [28:0] poe;
  } lsdc_state_t;

  lsdc_state_t st_reg;
  lsdc_state_t st_next;
  logic tick;
  logic run;
  logic acc;
  logic wr;
  logic [7:0] rel;
  logic [4:0] pidx;
  logic pix_hit;
  logic [1:0] segen_idx;
  logic wallow;
  logic last_slot;
  logic frame_ev;
  logic wfail_ev;
  logic [7:0] wbyte;
  logic seg_on;

  // pixel register index is valid for the sparse layout
  function automatic logic pix_valid(input logic [4:0] idx);
    pix_valid = (idx < 5'd12) || (idx == 5'd12) || (idx == 5'd15) ||
      (idx == 5'd18) || (idx == 5'd21);
  endfunction

  // pixel bit for a common and a segment
  function automatic logic pix_bit(input logic [23:0][7:0] pix,
    input logic [1:0] com, input int seg);
    logic [4:0] base;
    logic [4:0] r;
    base = 5'd0;
    r = 5'd0;
    base = 5'(3 * int'(com));
    if (seg < 24)
    begin
      r = base + 5'(seg / 8);
      pix_bit = pix[r][seg % 8];
    end
    else
    begin
      r = 5'd12 + base;
      pix_bit = pix[r][seg - 24];
    end
  endfunction

  // prescaled frame clock
  lsdc_prescale u_prescale (
    .ref_clk_in (ref_clk_in),
    .reset_in (reset_in),
    .run_in (run),
    .src_in (st_reg.src),
    .div_in (st_reg.pre),
    .tmr_tick_in (tmr_tick_in),
    .lfo_tick_in (lfo_tick_in),
    .tick_out (tick)
  );

  assign run = st_reg.on && !(sleep_in && st_reg.slp);

  // bus decode and frame sequencing
  always_comb
  begin
    st_next = st_reg;
    acc = wb_req_in.cyc && wb_req_in.stb && !st_reg.ack;
    wr = acc && wb_req_in.we && wb_req_in.sel[0];
    wbyte = wb_req_in.dat[7:0];
    rel = wb_req_in.adr - LSDC_PIX_OFS;
    pidx = rel[6:2];
    pix_hit = (wb_req_in.adr >= LSDC_PIX_OFS) && !rel[7] && (rel[1:0] == 2'b00) &&
      (pidx < 5'd24) && pix_valid(pidx);
    segen_idx = 2'(wb_req_in.adr[3:2]);
    // last slot of a running frame refuses pixel writes
    last_slot = (st_reg.com_idx == st_reg.mux) && (st_reg.wtype || st_reg.half);
    wallow = !(st_reg.active && last_slot);
    wfail_ev = 1'b0;
    frame_ev = 1'b0;
    seg_on = 1'b0;
    st_next.ack = acc;
    st_next.rdat = 32'h0000_0000;

    // register reads
    if (acc && !wb_req_in.we)
    begin
      if (wb_req_in.adr == LSDC_CTRL_OFS)
        st_next.rdat[7:0] = {st_reg.on, st_reg.slp, st_reg.wfail_flag, 1'b0,
          st_reg.src, st_reg.mux};
      else if (wb_req_in.adr == LSDC_PHASE_OFS)
        st_next.rdat[7:0] = {st_reg.wtype, st_reg.bias, st_reg.active, wallow,
          st_reg.pre};
      else if (wb_req_in.adr == LSDC_ISTAT_OFS)
        st_next.rdat[1:0] = st_reg.istat;
      else if (wb_req_in.adr == LSDC_IMASK_OFS)
        st_next.rdat[1:0] = st_reg.imask;
      else if ((wb_req_in.adr & 8'hf0) == LSDC_SEGEN_OFS && wb_req_in.adr[1:0] == 2'b00)
        st_next.rdat[7:0] = st_reg.segen[segen_idx];
      else if (pix_hit)
        st_next.rdat[7:0] = st_reg.pix[pidx];
    end

    // register writes, taken on the cycle the answer is raised
    if (wr)
    begin
      if (wb_req_in.adr == LSDC_CTRL_OFS)
      begin
        st_next.on = wbyte[LSDC_CTRL_ON_BIT];
        st_next.slp = wbyte[LSDC_CTRL_SLP_BIT];
        // software may only clear the error flag
        st_next.wfail_flag = st_reg.wfail_flag && wbyte[LSDC_CTRL_WFAIL_BIT];
        st_next.src = wbyte[LSDC_CTRL_SRC_LSB +: 2];
        st_next.mux = wbyte[LSDC_CTRL_MUX_LSB +: 2];
      end
      else if (wb_req_in.adr == LSDC_PHASE_OFS)
      begin
        st_next.wtype = wbyte[LSDC_PH_WTYPE_BIT];
        st_next.bias = wbyte[LSDC_PH_BIAS_BIT];
        st_next.pre = wbyte[LSDC_PH_PRE_LSB +: 4];
      end
      else if (wb_req_in.adr == LSDC_ISTAT_OFS)
        st_next.istat = st_reg.istat & ~wbyte[1:0];
      else if (wb_req_in.adr == LSDC_IMASK_OFS)
        st_next.imask = wbyte[1:0];
      else if ((wb_req_in.adr & 8'hf0) == LSDC_SEGEN_OFS && wb_req_in.adr[1:0] == 2'b00)
        st_next.segen[segen_idx] = wbyte;
      else if (pix_hit)
      begin
        // refused pixel write raises the error
        if (wallow)
          st_next.pix[pidx] = wbyte;
        else
          wfail_ev = 1'b1;
      end
    end

    // common counter stepped by the prescaled clock
    st_next.active = run;
    if (!run)
    begin
      st_next.com_idx = 2'b00;
      st_next.half = 1'b0;
      st_next.phase = 1'b0;
    end
    else if (tick)
    begin
      if (st_reg.wtype)
      begin
        // type B: one tick per common, phase flips per frame
        st_next.half = 1'b0;
        if (st_reg.com_idx >= st_reg.mux)
        begin
          st_next.com_idx = 2'b00;
          st_next.phase = !st_reg.phase;
          frame_ev = 1'b1;
        end
        else
          st_next.com_idx = st_reg.com_idx + 2'b01;
      end
      else
      begin
        // type A: phase flips inside each common slot
        st_next.half = !st_reg.half;
        st_next.phase = !st_reg.half;
        if (st_reg.half)
        begin
          if (st_reg.com_idx >= st_reg.mux)
          begin
            st_next.com_idx = 2'b00;
            frame_ev = 1'b1;
          end
          else
            st_next.com_idx = st_reg.com_idx + 2'b01;
        end
      end
    end

    // new commons setting restarts frame, keeps common in range
    if (wr && wb_req_in.adr == LSDC_CTRL_OFS && wbyte[LSDC_CTRL_MUX_LSB +: 2] != st_reg.mux)
    begin
      st_next.com_idx = 2'b00;
      st_next.half = 1'b0;
    end

    // sticky events, a set wins over a clear in the same cycle
    if (wfail_ev)
    begin
      st_next.wfail_flag = 1'b1;
      st_next.istat[LSDC_IRQ_WFAIL_BIT] = 1'b1;
    end
    if (frame_ev)
      st_next.istat[LSDC_IRQ_FRAME_BIT] = 1'b1;

    // common drive, only the selected commons while running
    st_next.com = 4'h0;
    if (st_next.active)
      st_next.com[st_next.com_idx] = 1'b1;

    for (int s = 0; s < LSDC_NUM_SEG; s++)
    begin
      seg_on = st_next.segen[s / 8][s % 8];
      // shared pad goes to common 3 in quarter mode
      if (LSDC_SHARED_PAD && s == LSDC_SHARED_SEG && st_next.mux == LSDC_MUX_QUARTER)
        seg_on = 1'b0;
      if (seg_on)
      begin
        st_next.pdat[s] = st_next.active &&
          (pix_bit(st_next.pix, st_next.com_idx, s) ^ st_next.phase);
        st_next.poe[s] = 1'b1;
      end
      else
      begin
        st_next.pdat[s] = gpio_dat_in[s];
        st_next.poe[s] = gpio_oe_in[s];
      end
    end
  end

  // state register
  always_ff @(posedge ref_clk_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      st_reg <= '0;
      st_reg.mux <= LSDC_CTRL_RST[1:0];
      st_reg.pre <= LSDC_PHASE_RST[3:0];
    end
    else
      st_reg <= st_next;
  end

  // outputs
  assign wb_rsp_out.ack = st_reg.ack;
  assign wb_rsp_out.dat = st_reg.rdat;
  assign com_out = st_reg.com;
  assign phase_out = st_reg.phase;
  // bias bit honoured only in two or three common modes
  assign bias_half_out = st_reg.bias &&
    (st_reg.mux == LSDC_MUX_HALF || st_reg.mux == LSDC_MUX_THIRD);
  assign pad_dat_out = st_reg.pdat;
  assign pad_oe_out = st_reg.poe;
  assign irq_out = |(st_reg.istat & st_reg.imask);

  // checks on the running logic
  default clocking cb @(posedge ref_clk_in);
  endclocking
  default disable iff (reset_in);

  property p_wfail;
    wr && pix_hit && !wallow |=> st_reg.wfail_flag && st_reg.istat[LSDC_IRQ_WFAIL_BIT];
  endproperty
  a_wfail: assert property (p_wfail) else $error("refused write left no error");

  property p_wfail_hold;
    st_reg.wfail_flag && !(wr && wb_req_in.adr == LSDC_CTRL_OFS) |=> st_reg.wfail_flag;
  endproperty
  a_wfail_hold: assert property (p_wfail_hold) else $error("error flag lost");

  property p_off;
    !run ##1 !run |-> st_reg.com == 4'h0 && !st_reg.active;
  endproperty
  a_off: assert property (p_off) else $error("commons driven while stopped");

  property p_sleep;
    st_reg.on && st_reg.slp && sleep_in |=> !st_reg.active;
  endproperty
  a_sleep: assert property (p_sleep) else $error("driver ran in sleep");

  property p_com_range;
    st_reg.active |-> st_reg.com_idx <= st_reg.mux;
  endproperty
  a_com_range: assert property (p_com_range) else $error("common past mux");

  property p_seg15;
    st_reg.mux == LSDC_MUX_QUARTER && $stable(st_reg.mux) |->
      st_reg.poe[LSDC_SHARED_SEG] == gpio_oe_in[LSDC_SHARED_SEG] || $changed(gpio_oe_in);
  endproperty
  a_seg15: assert property (p_seg15) else $error("segment 15 used in quarter mode");

  property p_bias;
    st_reg.mux == LSDC_MUX_STATIC || st_reg.mux == LSDC_MUX_QUARTER |-> !bias_half_out;
  endproperty
  a_bias: assert property (p_bias) else $error("half bias in static or quarter");

  property p_typeb;
    st_reg.active && st_reg.wtype && tick && st_reg.com_idx != st_reg.mux && $stable(st_reg.wtype)
      |=> $stable(st_reg.phase);
  endproperty
  a_typeb: assert property (p_typeb) else $error("type B phase flipped mid frame");

  property p_ack;
    st_reg.ack |=> !st_reg.ack;
  endproperty
  a_ack: assert property (p_ack) else $error("ack held two cycles");

endmodule

`default_nettype wire

// *** lsdc_panel_model.sv ***
`timescale 1ns/1ps
`default_nettype none

module lsdc_panel_model
  import lsdc_pkg::*;
(
  input wire logic ref_clk_in, // system clock
  input wire logic clr_in, // clears the seen commons
  input wire logic [3:0] com_in, // one-hot common from the driver
  input wire logic phase_in, // waveform phase
  input wire logic [28:0] pad_dat_in, // pad levels
  input wire logic [28:0] pad_oe_in, // pad enables
  output logic [28:0] dark_out, // segments dark on the active common
  output logic [3:0] seen_out // commons driven since the last clear
);
  // a driven segment is dark when its level is opposite to the phase
  // dark pixel decode
  assign dark_out = (pad_dat_in ^ {29{phase_in}}) & pad_oe_in;

  // collect the commons that the glass has been driven on
  // up to four commons
  always_ff @(posedge ref_clk_in)
  begin
    if (clr_in)
      seen_out <= 4'h0;
    else
      seen_out <= seen_out | com_in;
  end
endmodule

`default_nettype wire

// *** lsdc_pkg.sv ***
`default_nettype none

package lsdc_pkg;

  // register byte offsets on the bus
  localparam logic [7:0] LSDC_CTRL_OFS = 8'h00;
  localparam logic [7:0] LSDC_PHASE_OFS = 8'h04;
  localparam logic [7:0] LSDC_ISTAT_OFS = 8'h08;
  localparam logic [7:0] LSDC_IMASK_OFS = 8'h0c;
  localparam logic [7:0] LSDC_SEGEN_OFS = 8'h10;
  localparam logic [7:0] LSDC_PIX_OFS = 8'h40;

  // values after reset
  localparam logic [7:0] LSDC_CTRL_RST = 8'h03;
  localparam logic [7:0] LSDC_PHASE_RST = 8'h03;

  // control register fields
  localparam int LSDC_CTRL_ON_BIT = 7;
  localparam int LSDC_CTRL_SLP_BIT = 6;
  localparam int LSDC_CTRL_WFAIL_BIT = 5;
  localparam int LSDC_CTRL_SRC_LSB = 2;
  localparam int LSDC_CTRL_MUX_LSB = 0;

  // phase and prescale register fields
  localparam int LSDC_PH_WTYPE_BIT = 7;
  localparam int LSDC_PH_BIAS_BIT = 6;
  localparam int LSDC_PH_ACT_BIT = 5;
  localparam int LSDC_PH_WALLOW_BIT = 4;
  localparam int LSDC_PH_PRE_LSB = 0;

  // interrupt status and mask bits
  localparam int LSDC_IRQ_WFAIL_BIT = 0;
  localparam int LSDC_IRQ_FRAME_BIT = 1;

  // multiplex and clock source encodings
  localparam logic [1:0] LSDC_MUX_STATIC = 2'b00;
  localparam logic [1:0] LSDC_MUX_HALF = 2'b01;
  localparam logic [1:0] LSDC_MUX_THIRD = 2'b10;
  localparam logic [1:0] LSDC_MUX_QUARTER = 2'b11;
  localparam logic [1:0] LSDC_SRC_FOSC = 2'b00;
  localparam logic [1:0] LSDC_SRC_TMR = 2'b01;

  // system clock divided by 256 gives the fosc source
  localparam logic [7:0] LSDC_FOSC_DIV_LAST = 8'hff;

  // panel geometry
  localparam int LSDC_NUM_SEG = 29;
  localparam int LSDC_NUM_COM = 4;
  localparam int LSDC_NUM_PIX = 24;
  localparam int LSDC_NUM_SEGEN = 4;
  localparam int LSDC_SHARED_SEG = 15;
  localparam logic LSDC_SHARED_PAD = 1'b1;

  // classic wishbone request and answer
  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } lsdc_wb_req_t;

  typedef struct packed {
    logic ack;
    logic [31:0] dat;
  } lsdc_wb_rsp_t;

endpackage

`default_nettype wire

// *** lsdc_prescale.sv ***
`timescale 1ns/1ps
`default_nettype none

module lsdc_prescale
  import lsdc_pkg::*;
(
  input wire logic ref_clk_in, // system clock
  input wire logic reset_in, // async reset, active high
  input wire logic run_in, // count only while driver runs
  input wire logic [1:0] src_in, // clock source select
  input wire logic [3:0] div_in, // prescale code, ratio code+1
  input wire logic tmr_tick_in, // secondary timer osc event
  input wire logic lfo_tick_in, // low-frequency osc event
  output logic tick_out // one pulse per prescaled period
);

  typedef struct packed {
    logic [7:0] fdiv;
    logic [3:0] pcnt;
    logic tick;
  } lsdc_ps_state_t;

  lsdc_ps_state_t st_reg;
  lsdc_ps_state_t st_next;
  logic src_ev;

  // source select and prescale counter
  always_comb
  begin
    st_next = st_reg;
    st_next.tick = 1'b0;
    st_next.fdiv = st_reg.fdiv + 8'h01;
    if (src_in == LSDC_SRC_FOSC)
      src_ev = (st_reg.fdiv == LSDC_FOSC_DIV_LAST);
    else if (src_in == LSDC_SRC_TMR)
      src_ev = tmr_tick_in;
    else
      src_ev = lfo_tick_in;
    if (!run_in)
    begin
      st_next.pcnt = 4'h0;
    end
    else if (src_ev)
    begin
      if (st_reg.pcnt >= div_in)
      begin
        st_next.pcnt = 4'h0;
        st_next.tick = 1'b1;
      end
      else
        st_next.pcnt = st_reg.pcnt + 4'h1;
    end
  end

  // state register
  always_ff @(posedge ref_clk_in or posedge reset_in)
  begin
    if (reset_in)
      st_reg <= '0;
    else
      st_reg <= st_next;
  end

  assign tick_out = st_reg.tick;

endmodule

`default_nettype wire

// *** tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none

`define CHK(nm, ex, gt) \
  begin \
    comparisons++; \
    if ((gt) !== (ex)) \
    begin \
      fail_count++; \
      $display("[ERR] %s expected %h seen %h", nm, ex, gt); \
    end \
  end

module tb_top;
  import lsdc_pkg::*;
  logic ref_clk_in, reset_in, sleep, phase, bias_half, irq, seen_clr;
  logic tmr_tick = 1'b0;
  logic lfo_tick = 1'b0;
  lsdc_wb_req_t wb_req;
  lsdc_wb_rsp_t wb_rsp;
  logic [3:0] com, seen;
  logic [28:0] pad_dat, pad_oe, dark, gpio_dat, gpio_oe;
  logic [2:0] lfo_cnt = 3'h0;
  logic [2:0] tmr_cnt = 3'h0;
  int fail_count, comparisons;

  lsdc_driver i_dut (.ref_clk_in(ref_clk_in), .reset_in(reset_in), .wb_req_in(wb_req),
    .wb_rsp_out(wb_rsp), .sleep_in(sleep), .tmr_tick_in(tmr_tick), .lfo_tick_in(lfo_tick),
    .gpio_dat_in(gpio_dat), .gpio_oe_in(gpio_oe), .com_out(com), .phase_out(phase),
    .bias_half_out(bias_half), .pad_dat_out(pad_dat), .pad_oe_out(pad_oe), .irq_out(irq));

  lsdc_panel_model i_panel (.ref_clk_in(ref_clk_in), .clr_in(seen_clr), .com_in(com),
    .phase_in(phase), .pad_dat_in(pad_dat), .pad_oe_in(pad_oe), .dark_out(dark),
    .seen_out(seen));

  // 100 MHz clock
  initial
  begin
    ref_clk_in = 1'b0;
    forever #5 ref_clk_in = ~ref_clk_in;
  end

  // oscillator events: low-frequency every 4 cycles, timer every 6
  always @(posedge ref_clk_in)
  begin
    lfo_cnt <= (lfo_cnt == 3'h3) ? 3'h0 : lfo_cnt + 3'h1;
    lfo_tick <= (lfo_cnt == 3'h3);
    tmr_cnt <= (tmr_cnt == 3'h5) ? 3'h0 : tmr_cnt + 3'h1;
    tmr_tick <= (tmr_cnt == 3'h5);
  end

  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic timeout_hit();
    fail_count++;
    $display("[ERR] wait ran out");
    print_verdict();
  endtask

  // one classic cycle, held until ack is sampled high
  task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d,
      output logic [7:0] q);
    int n;
    n = 0;
    @(posedge ref_clk_in);
    wb_req <= '{cyc: 1'b1, stb: 1'b1, we: w, adr: a, sel: 4'hf, dat: {24'h0, d}};
    do
    begin
      @(posedge ref_clk_in);
      n++;
    end
    while (wb_rsp.ack !== 1'b1 && n < 20);
    if (wb_rsp.ack !== 1'b1)
      timeout_hit();
    q = wb_rsp.dat[7:0];
    wb_req <= '0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] q;
    xfer(1'b1, a, d, q);
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] q);
    xfer(1'b0, a, 8'h00, q);
  endtask

  // cycles between changes of the common or of the phase
  task automatic measure(input logic use_ph, output int per);
    logic [3:0] prev;
    int n;
    per = 0;
    for (int k = 0; k < 3; k++)
    begin
      prev = use_ph ? {3'h0, phase} : com;
      n = 0;
      do
      begin
        @(posedge ref_clk_in);
        n++;
      end
      while ((use_ph ? {3'h0, phase} : com) === prev && n < 3000);
      if (n >= 3000)
        timeout_hit();
      per = n;
    end
  endtask

  task automatic t_reset();
    logic [7:0] q;
    rd(LSDC_CTRL_OFS, q);
    `CHK("ctrl", LSDC_CTRL_RST, q)
    rd(LSDC_PHASE_OFS, q);
    `CHK("phase", LSDC_PHASE_RST | (8'h01 << LSDC_PH_WALLOW_BIT), q)
    rd(8'h30, q);
    `CHK("unmapped", 8'h00, q)
    `CHK("pad oe", gpio_oe, pad_oe)
    `CHK("pad dat", gpio_dat, pad_dat)
    gpio_dat <= 29'h0aaa_aaaa;
    gpio_oe <= 29'h0aaa_aaaa;
    repeat (2) @(posedge ref_clk_in);
    `CHK("pad oe io", 29'h0aaa_aaaa, pad_oe)
    `CHK("pad dat io", 29'h0aaa_aaaa, pad_dat)
    gpio_dat <= 29'h1fff_ffff;
    gpio_oe <= 29'h1555_5555;
    `CHK("com idle", 4'h0, com)
    $display("test reset done");
  endtask

  task automatic t_regs();
    logic [7:0] q;
    for (int i = 0; i < 3; i++)
      wr(LSDC_SEGEN_OFS + 8'(4 * i), 8'hff);
    wr(LSDC_SEGEN_OFS + 8'h0c, 8'h1f);
    rd(LSDC_SEGEN_OFS + 8'h0c, q);
    `CHK("segen3", 8'h1f, q)
    wr(LSDC_PIX_OFS, 8'ha5);
    wr(LSDC_PIX_OFS + 8'h30, 8'h15);
    rd(LSDC_PIX_OFS + 8'h30, q);
    `CHK("pix12", 8'h15, q)
    repeat (2) @(posedge ref_clk_in);
    `CHK("seg oe", 29'h1fff_7fff, pad_oe)
    `CHK("pads stopped", 29'h0, pad_dat & pad_oe)
    $display("test registers done");
  endtask

  task automatic t_static();
    logic [7:0] q;
    int per;
    wr(LSDC_PHASE_OFS, 8'h80);
    wr(LSDC_CTRL_OFS, 8'h80);
    measure(1'b1, per);
    `CHK("frame period", 256, per)
    `CHK("static com", 4'h1, com)
    `CHK("dark 7:0", 8'ha5, dark[7:0])
    `CHK("dark 28:24", 5'h15, dark[28:24])
    rd(LSDC_PHASE_OFS, q);
    `CHK("active", 1'b1, q[LSDC_PH_ACT_BIT])
    `CHK("write allow", 1'b0, q[LSDC_PH_WALLOW_BIT])
    wr(LSDC_IMASK_OFS, 8'h01);
    wr(LSDC_PIX_OFS, 8'h3c);
    rd(LSDC_PIX_OFS, q);
    `CHK("pix kept", 8'ha5, q)
    rd(LSDC_CTRL_OFS, q);
    `CHK("wfail set", 1'b1, q[LSDC_CTRL_WFAIL_BIT])
    `CHK("irq fail", 1'b1, irq)
    wr(LSDC_CTRL_OFS, 8'h80);
    wr(LSDC_ISTAT_OFS, 8'h03);
    rd(LSDC_CTRL_OFS, q);
    `CHK("wfail clr", 1'b0, q[LSDC_CTRL_WFAIL_BIT])
    `CHK("irq clr", 1'b0, irq)
    wr(LSDC_IMASK_OFS, 8'h02);
    repeat (300) @(posedge ref_clk_in);
    `CHK("irq frame", 1'b1, irq)
    wr(LSDC_IMASK_OFS, 8'h00);
    @(posedge ref_clk_in);
    `CHK("irq masked", 1'b0, irq)
    $display("test static done");
  endtask

  task automatic t_sleep();
    logic [7:0] q;
    wr(LSDC_CTRL_OFS, 8'hc0);
    sleep <= 1'b1;
    repeat (4) @(posedge ref_clk_in);
    `CHK("sleep com", 4'h0, com)
    rd(LSDC_PHASE_OFS, q);
    `CHK("sleep idle", 1'b0, q[LSDC_PH_ACT_BIT])
    wr(LSDC_CTRL_OFS, 8'h80);
    rd(LSDC_PHASE_OFS, q);
    `CHK("sleep run", 1'b1, q[LSDC_PH_ACT_BIT])
    sleep <= 1'b0;
    wr(LSDC_CTRL_OFS, 8'h00);
    repeat (4) @(posedge ref_clk_in);
    `CHK("off com", 4'h0, com)
    `CHK("off pads", 29'h0, pad_dat)
    $display("test sleep done");
  endtask

  task automatic t_modes();
    int per;
    wr(LSDC_PHASE_OFS, 8'h02);
    wr(LSDC_CTRL_OFS, 8'h8f);
    measure(1'b0, per);
    `CHK("quarter period", 24, per)
    measure(1'b1, per);
    `CHK("type a phase", 12, per)
    seen_clr <= 1'b1;
    @(posedge ref_clk_in);
    seen_clr <= 1'b0;
    repeat (100) @(posedge ref_clk_in);
    `CHK("four commons", 4'hf, seen)
    `CHK("shared pad", gpio_oe[15], pad_oe[15])
    wr(LSDC_PHASE_OFS, 8'h42);
    `CHK("bias quarter", 1'b0, bias_half)
    wr(LSDC_CTRL_OFS, 8'h89);
    repeat (2) @(posedge ref_clk_in);
    `CHK("bias half", 1'b1, bias_half)
    `CHK("seg15 back", 1'b1, pad_oe[15])
    wr(LSDC_PHASE_OFS, 8'h80);
    wr(LSDC_CTRL_OFS, 8'h85);
    measure(1'b0, per);
    `CHK("timer period", 6, per)
    wr(LSDC_CTRL_OFS, 8'h86);
    repeat (20) @(posedge ref_clk_in);
    seen_clr <= 1'b1;
    @(posedge ref_clk_in);
    seen_clr <= 1'b0;
    repeat (60) @(posedge ref_clk_in);
    `CHK("three commons", 4'h7, seen)
    wr(LSDC_PHASE_OFS, 8'h81);
    wr(LSDC_CTRL_OFS, 8'h81);
    measure(1'b0, per);
    `CHK("fosc period", 512, per)
    $display("test modes done");
  endtask

  // reset, then the scenarios in turn
  initial
  begin
    reset_in = 1'b1;
    wb_req = '0;
    sleep = 1'b0;
    seen_clr = 1'b0;
    gpio_dat = 29'h1fff_ffff;
    gpio_oe = 29'h1555_5555;
    fail_count = 0;
    comparisons = 0;
    repeat (4) @(posedge ref_clk_in);
    reset_in <= 1'b0;
    t_reset();
    t_regs();
    t_static();
    t_sleep();
    t_modes();
    print_verdict();
  end
endmodule

`default_nettype wire
